// file: test/sapc_host.sv
module sapc_host (
  input wire logic clk,
  input wire logic [15:0] dac_code,
  output logic cs_n,
  output logic rd_conv,
  output logic byte_sel,
  output logic cmp_above
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] vin = 16'h0000;

  // Ideal front end: input at or above the trial code keeps the bit
  assign cmp_above = (vin >= dac_code);

  initial begin
    cs_n = 1'b1;
    rd_conv = 1'b1;
    byte_sel = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start by select edge, or by convert edge with select left low to read
  task automatic start(input logic via_cs, input logic bs, input logic [15:0] v);
    @(negedge clk);
    vin = v;
    byte_sel = bs;
    if (via_cs) begin
      rd_conv = 1'b0;
      @(negedge clk);
      cs_n = 1'b0;
    end else begin
      cs_n = 1'b0;
      @(negedge clk);
      rd_conv = 1'b0;
    end
    repeat (3) @(negedge clk);
    rd_conv = 1'b1;
    if (via_cs) begin
      cs_n = 1'b1;
    end
  endtask

  // Convert held low across the end of a conversion, as a careless host would
  task automatic convert_held(input logic [15:0] v, input int len);
    @(negedge clk);
    vin = v;
    cs_n = 1'b0;
    rd_conv = 1'b0;
    repeat (len) @(negedge clk);
    rd_conv = 1'b1;
    cs_n = 1'b1;
  endtask

  task automatic release_bus();
    @(negedge clk);
    cs_n = 1'b1;
  endtask

  task automatic read(input logic bs, input int len);
    @(negedge clk);
    byte_sel = bs;
    cs_n = 1'b0;
    repeat (len) @(negedge clk);
    cs_n = 1'b1;
  endtask
endmodule // sapc_host

// file: test/sapc_top_test.sv
module sapc_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n;
  logic rd_conv;
  logic byte_sel;
  logic cmp_above;
  logic busy_n;
  logic hold;
  logic [15:0] dac_code;
  logic [15:0] data_out;
  logic data_oe;
  wire logic [15:0] dbus;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  assign dbus = data_oe ? data_out : 16'hzzzz;

  sapc_top DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_conv(rd_conv), .byte_sel(byte_sel),
    .cmp_above(cmp_above), .busy_n(busy_n), .hold(hold), .dac_code(dac_code),
    .data_out(data_out), .data_oe(data_oe));

  sapc_host host (.clk(clk), .dac_code(dac_code), .cs_n(cs_n), .rd_conv(rd_conv),
    .byte_sel(byte_sel), .cmp_above(cmp_above));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Output watcher: read latency, released bus, busy length, read data
  int rd_cnt = 0;
  int idle_cnt = 0;
  int low_cnt = 0;
  logic oe_q = 1'b0;
  // Pins are counted at the rising edge, outputs looked at on the falling edge once settled
  always @(posedge clk) begin
    rd_cnt = (!cs_n && rd_conv) ? rd_cnt + 1 : 0;
    idle_cnt = (cs_n || !rd_conv) ? idle_cnt + 1 : 0;
  end

  always @(negedge clk) begin
    if (rst) begin
      low_cnt = 0;
      oe_q = 1'b0;
    end else begin
      if (data_oe === 1'b1 && oe_q !== 1'b1) begin
        check(16'(rd_cnt <= 4), 16'h0001);
        if (exp_q.size() == 0) begin
          check(16'h0000, 16'h0001);
        end else begin
          check(dbus, exp_q.pop_front());
        end
      end
      if (idle_cnt > 4) begin
        check(16'(data_oe), 16'h0000);
      end
      if (busy_n === 1'b0) begin
        low_cnt++;
      end else if (low_cnt > 0) begin
        check(16'(low_cnt >= 384 && low_cnt <= 400), 16'h0001);
        low_cnt = 0;
      end
      oe_q = data_oe;
    end
  end

  function automatic logic [15:0] pins(input logic [15:0] w, input logic bs);
    return bs ? {w[7:0], w[15:8]} : w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic [15:0] prev;
    logic bs;
    prev = 16'h0000;
    void'($urandom(32'h372e));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    check(16'(busy_n), 16'h0001);
    check(16'(data_oe), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom);
      bs = i[1];
      if (!i[0]) begin
        // Select leads the convert edge by a cycle and reads once; the release reads again
        exp_q.push_back(pins(prev, bs));
        exp_q.push_back(pins(prev, bs));
      end
      host.start(i[0], bs, v);
      check(16'(busy_n), 16'h0000);
      check(16'(hold), 16'h0001);
      check(dac_code, 16'h8000);
      if (!i[0]) begin
        repeat (8) @(negedge clk);
        host.release_bus();
      end
      if (i == 3) begin
        host.start(1'b1, bs, v);
      end
      for (int k = 0; k < 500 && busy_n !== 1'b1; k++) begin
        @(negedge clk);
      end
      repeat (8) @(negedge clk);
      check(16'(busy_n), 16'h0001);
      exp_q.push_back(pins(v, bs));
      host.read(bs, 6);
      repeat (8) @(negedge clk);
      prev = v;
    end
    // Convert held across the busy rise: the next conversion follows at once
    v = 16'($urandom);
    host.convert_held(v, 420);
    check(16'(busy_n), 16'h0000);
    check(16'(hold), 16'h0001);
    for (int k = 0; k < 500 && busy_n !== 1'b1; k++) begin
      @(negedge clk);
    end
    repeat (8) @(negedge clk);
    check(16'(busy_n), 16'h0001);
    exp_q.push_back(pins(v, 1'b1));
    host.read(1'b1, 6);
    repeat (8) @(negedge clk);
    check(16'(exp_q.size()), 16'h0000);
    test_done();
  end

  initial begin
    #200000;
    num_errors++;
    test_done();
  end
endmodule // sapc_top_test

// file: verilog/sapc_buf2.sv
`include "sapc_defines.svh"

module sapc_buf2 #(
  parameter int WIDTH = `SAPC_WORD_W,
  parameter int DEPTH = `SAPC_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != FULL);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule // sapc_buf2

// file: verilog/sapc_defines.svh
`ifndef SAPC_DEFINES_SVH
`define SAPC_DEFINES_SVH

`define SAPC_CLK_MHZ 50
`define SAPC_WORD_W 16
`define SAPC_BUF_DEPTH 2
`define SAPC_SAR_MSB 16'h8000
`define SAPC_WORD_ZERO 16'h0000
// Printed times in ns
`define SAPC_T_PULSE_NS 40
`define SAPC_T_CONV_NS 8000
`define SAPC_T_BUSY_NS 220
`define SAPC_T_LEAD_NS 50
`define SAPC_T_PREV_NS 7400
`define SAPC_T_ACCESS_NS 83
// Cycle counts: least times round up, longest times round down
`define SAPC_CYC_UP(ns) (((ns) * `SAPC_CLK_MHZ + 999) / 1000)
`define SAPC_CYC_DN(ns) (((ns) * `SAPC_CLK_MHZ) / 1000)
`define SAPC_PULSE_CYC `SAPC_CYC_UP(`SAPC_T_PULSE_NS)
`define SAPC_CONV_CYC `SAPC_CYC_DN(`SAPC_T_CONV_NS)
`define SAPC_BUSY_CYC `SAPC_CYC_DN(`SAPC_T_BUSY_NS)
`define SAPC_LEAD_CYC `SAPC_CYC_UP(`SAPC_T_LEAD_NS)
`define SAPC_PREV_CYC `SAPC_CYC_DN(`SAPC_T_PREV_NS)
`define SAPC_ACCESS_CYC `SAPC_CYC_DN(`SAPC_T_ACCESS_NS)
// Cycles per bit decision: 16 bits fit inside the conversion time
`define SAPC_BIT_CYC 24

`endif

// file: verilog/sapc_pkg.sv
`include "sapc_defines.svh"

package sapc_pkg;
  typedef logic [`SAPC_WORD_W-1:0] sapc_word_type;
  typedef struct packed {
    logic cs_n;
    logic rd_conv;
    logic byte_sel;
  } sapc_ctl_type;
  typedef enum logic [2:0] {
    SAPC_IDLE,
    SAPC_CONV,
    SAPC_PUSH,
    SAPC_WAIT,
    SAPC_FLAG
  } sapc_state_type;
endpackage

// file: verilog/sapc_top.sv
// Functional notes
// - Convert edge with select low starts conversion
// - Rising convert edge enables result output
// - Select falling while convert low starts
// - Select falling while convert high reads
// - Outputs released when deselected or convert low
// - Byte select swaps upper and lower halves
// - Busy low throughout conversion, data valid after
// - Result valid within 8 us of start; the finished word waits in the buffer while outputs are enabled
// - Busy rises about 220 ns after end
// - Result leads busy rise by 50 ns minimum
// - Previous result readable about 7.4 us
// - Output data valid within 83 ns
// - Start requests ignored during a conversion
`include "sapc_defines.svh"

module sapc_top
  import sapc_pkg::*;
#(
  parameter int BIT_CYC = `SAPC_BIT_CYC,
  parameter int BUSY_CYC = `SAPC_BUSY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_conv,
  input wire logic byte_sel,
  input wire logic cmp_above,
  output logic busy_n,
  output logic hold,
  output logic [`SAPC_WORD_W-1:0] dac_code,
  output logic [`SAPC_WORD_W-1:0] data_out,
  output logic data_oe
);

  function automatic sapc_word_type sapc_swap(input sapc_word_type w);
    return {w[7:0], w[15:8]};
  endfunction

  function automatic sapc_word_type sapc_step(input sapc_word_type w,
                                              input logic [3:0] idx,
                                              input logic keep);
    sapc_word_type r;
    r = w;
    r[idx] = keep;
    if (idx != 4'h0) begin
      r[idx - 4'h1] = 1'b1;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  sapc_ctl_type ctl_pin;
  sapc_ctl_type ctl_meta_reg;
  sapc_ctl_type ctl_sync_reg;
  logic cmp_meta_reg;
  logic cmp_sync_reg;
  logic req_prev_reg;
  logic conv_req;
  logic read_en;

  assign ctl_pin = '{cs_n: cs_n, rd_conv: rd_conv, byte_sel: byte_sel};

  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_meta_reg <= '{cs_n: 1'b1, rd_conv: 1'b1, byte_sel: 1'b0};
      ctl_sync_reg <= '{cs_n: 1'b1, rd_conv: 1'b1, byte_sel: 1'b0};
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
      req_prev_reg <= 1'b0;
    end else begin
      ctl_meta_reg <= ctl_pin;
      ctl_sync_reg <= ctl_meta_reg;
      cmp_meta_reg <= cmp_above;
      cmp_sync_reg <= cmp_meta_reg;
      req_prev_reg <= conv_req;
    end
  end

  // Select and convert are ORed: either falling while the other is low
  assign conv_req = !ctl_sync_reg.cs_n && !ctl_sync_reg.rd_conv;
  assign read_en = !ctl_sync_reg.cs_n && ctl_sync_reg.rd_conv;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  sapc_state_type state_reg;
  sapc_word_type sar_reg;
  logic [3:0] bit_idx_reg;
  logic [$clog2(BIT_CYC+1)-1:0] cyc_reg;
  logic [$clog2(BUSY_CYC+1)-1:0] flag_cnt_reg;
  logic rearm_reg;
  logic busy_n_reg;
  logic hold_reg;
  logic start;
  logic buf_in_ready;
  logic buf_out_valid;
  logic latch_ready;
  logic pop;
  sapc_word_type buf_out_data;
  logic data_oe_reg;

  // A request still held when busy rises starts at once
  assign start = conv_req && (!req_prev_reg || rearm_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= SAPC_IDLE;
      sar_reg <= `SAPC_WORD_ZERO;
      bit_idx_reg <= 4'hf;
      cyc_reg <= '0;
      flag_cnt_reg <= '0;
      rearm_reg <= 1'b0;
    end else begin
      rearm_reg <= 1'b0;
      case (state_reg)
        SAPC_IDLE: begin
          // Only this state looks at requests
          if (start) begin
            state_reg <= SAPC_CONV;
            sar_reg <= `SAPC_SAR_MSB;
            bit_idx_reg <= 4'hf;
            cyc_reg <= '0;
          end
        end
        SAPC_CONV: begin
          if (cyc_reg == ($bits(cyc_reg))'(BIT_CYC - 1)) begin
            cyc_reg <= '0;
            sar_reg <= sapc_step(sar_reg, bit_idx_reg, cmp_sync_reg);
            if (bit_idx_reg == 4'h0) begin
              state_reg <= SAPC_PUSH;
            end else begin
              bit_idx_reg <= bit_idx_reg - 4'h1;
            end
          end else begin
            cyc_reg <= cyc_reg + 1'b1;
          end
        end
        SAPC_PUSH: begin
          if (buf_in_ready) begin
            state_reg <= SAPC_WAIT;
          end
        end
        SAPC_WAIT: begin
          if (pop) begin
            state_reg <= SAPC_FLAG;
            flag_cnt_reg <= '0;
          end
        end
        SAPC_FLAG: begin
          if (flag_cnt_reg == ($bits(flag_cnt_reg))'(BUSY_CYC - 1)) begin
            state_reg <= SAPC_IDLE;
            rearm_reg <= 1'b1;
          end else begin
            flag_cnt_reg <= flag_cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= SAPC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_n_reg <= 1'b1;
      hold_reg <= 1'b0;
    end else begin
      if (state_reg == SAPC_IDLE && start) begin
        busy_n_reg <= 1'b0;
        hold_reg <= 1'b1;
      end else if (state_reg == SAPC_FLAG &&
                   flag_cnt_reg == ($bits(flag_cnt_reg))'(BUSY_CYC - 1)) begin
        busy_n_reg <= 1'b1;
      end
      if (state_reg == SAPC_CONV && bit_idx_reg == 4'h0 &&
          cyc_reg == ($bits(cyc_reg))'(BIT_CYC - 1)) begin
        hold_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result buffer and output latch

  // The latch is not refilled while outputs are enabled, but a pop in the cycle they turn on changes the word one cycle into the read
  assign latch_ready = !data_oe_reg;
  assign pop = buf_out_valid && latch_ready;

  sapc_buf2 #(
    .WIDTH(`SAPC_WORD_W),
    .DEPTH(`SAPC_BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .in_data(sar_reg),
    .in_valid(state_reg == SAPC_PUSH),
    .in_ready(buf_in_ready),
    .out_data(buf_out_data),
    .out_valid(buf_out_valid),
    .out_ready(latch_ready)
  );

  sapc_word_type result_reg;
  logic [`SAPC_WORD_W-1:0] data_out_reg;

  // Old result stays in the latch until the new word is complete
  always_ff @(posedge clk) begin
    if (rst) begin
      result_reg <= `SAPC_WORD_ZERO;
    end else if (pop) begin
      result_reg <= buf_out_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_out_reg <= `SAPC_WORD_ZERO;
      data_oe_reg <= 1'b0;
    end else begin
      data_out_reg <= ctl_sync_reg.byte_sel ? sapc_swap(result_reg) : result_reg;
      data_oe_reg <= read_en;
    end
  end

  assign busy_n = busy_n_reg;
  assign hold = hold_reg;
  assign dac_code = sar_reg;
  assign data_out = data_out_reg;
  assign data_oe = data_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int CONV_LEN = 16 * BIT_CYC;
  localparam int BUSY_LEN = BUSY_CYC + 1;

  logic [9:0] since_start_reg;
  logic [7:0] since_pop_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      since_start_reg <= '0;
      since_pop_reg <= '0;
    end else begin
      since_start_reg <= (state_reg == SAPC_IDLE) ? '0 : since_start_reg + 1'b1;
      since_pop_reg <= pop ? 8'h01 : since_pop_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_start;
    state_reg == SAPC_IDLE && conv_req && !req_prev_reg |=> !busy_n_reg && hold_reg;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_read_on;
    read_en |=> data_oe_reg;
  endproperty
  a_read_on: assert property (p_read_on) else $error("output not enabled");

  property p_hiz;
    !read_en |=> !data_oe_reg;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while released");

  property p_swap;
    ctl_sync_reg.byte_sel |=> data_out_reg == sapc_swap($past(result_reg));
  endproperty
  a_swap: assert property (p_swap) else $error("bytes not swapped");

  property p_busy_low;
    state_reg == SAPC_CONV || state_reg == SAPC_WAIT |-> !busy_n_reg;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy high in conversion");

  property p_conv_len;
    state_reg == SAPC_CONV ##1 state_reg == SAPC_PUSH |-> since_start_reg == CONV_LEN;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_busy_lead;
    $rose(busy_n_reg) |-> since_pop_reg == BUSY_LEN;
  endproperty
  a_busy_lead: assert property (p_busy_lead) else $error("busy lead wrong");

  property p_prev_hold;
    state_reg == SAPC_CONV |=> $stable(result_reg);
  endproperty
  a_prev_hold: assert property (p_prev_hold) else $error("old result lost");

  property p_ignore;
    $rose(hold_reg) |-> $past(state_reg) == SAPC_IDLE;
  endproperty
  a_ignore: assert property (p_ignore) else $error("restart during conversion");
endmodule // sapc_top
